// ### spc_map.vh
// Constants for the auxiliary pin function select block.
// Assumes inclusion by the block's single design file only.
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
`define SPC_REG_RESET 16'h0004
`define SPC_DRIVE_BIT 1
`define SPC_RDLY_BIT 0
`define SPC_SYNC_LO 2
`define SPC_SYNC_HI 3
`define SPC_AUX1_LO 4
`define SPC_AUX1_HI 5
`define SPC_AUX2_LO 6
`define SPC_AUX2_HI 7
`define SPC_CHAN_BIT 14
`define SPC_RW_MASK 16'h40ff
`define SPC_SYNC_OFF 2'h0
`define SPC_SYNC_DEF 2'h1
`define SPC_SYNC_ALT 2'h2
`define SPC_AUX_OFF 2'h0
`define SPC_AUX_RDY 2'h1
`define SPC_AUX_SOUT 2'h2
`define SPC_AUX2_START 2'h2
`define SPC_DIV4_CODE 2'h2
`define SPC_DIV8_CODE 2'h3
`define SPC_DIV2_LAT 4'h3
`define SPC_DIV4_LAT 4'h5
`define SPC_DIV8_LAT 4'h9
`endif

// ### spc_pin_ctrl.v
// Auxiliary pin function select: sync-out role, sync-in modes, ready release.
// Assumes the serial port delivers register writes and reads as strobes and
// that clk is the converter's main clock; inputs are synchronous to clk.
// Drive strength and the channel-number bit are only stored here; the pads
// and the channel output are handled outside this block.
// Function
// - Aux one code 10 drives the pin as synchronized start output.
// - Sync config field bits [3:2], resets to 01; code 00 disables it.
// - Sync config 01 makes sync input active low, default behaviour.
// - Default mode low input resets modulator, filter, logic and sequencer.
// - Sync config 10: low sync input stops sequencer advancing.
// - Alternative mode advances only when sync high; sequencer not reset.
// - Alternative mode has no effect with one enabled channel.
// - Release bit picks last serial clock edge (0) or chip-select rise (1).
// - Release bit ignored when ready goes out on aux one.
// - Sync output delay 3-4, 5-8, 9-16 main clocks at div 2, 4, 8.
// - Ready on aux one disables ready on shared serial output pin.
`timescale 1ns/1ps
`include "spc_map.vh"
module spc_pin_ctrl (
    input wire clk,
    input wire rstn,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    input wire [1:0] clock_div_sel,
    input wire multi_chan,
    input wire seq_step_req,
    input wire sync_in_n,
    input wire start_in,
    input wire data_ready,
    input wire read_active,
    input wire last_sclk_rise,
    input wire cs_rise,
    output wire core_reset,
    output wire seq_reset,
    output wire seq_advance,
    output reg aux_one_out,
    output reg aux_one_oe,
    output wire sdo_ready_en,
    output wire sdo_ready_n,
    output wire output_drive_boost
);
    reg [15:0] aux_pin_function_select_ff;
    reg [15:0] nxt_sel;

    reg rdy_hold_ff;
    reg nxt_rdy_hold;

    reg [3:0] dly_cnt_ff;
    reg [3:0] nxt_dly_cnt;
    reg start_ff;
    reg sync_out_ff;
    reg nxt_sync_out;
    reg [3:0] lat;

    reg sync_hold_core;
    reg sync_hold_step;

    wire [1:0] sync_mode;
    wire [1:0] aux_one_function;
    wire ready_release_select;
    wire rdy_on_aux;
    wire start_edge;
    wire rdy_release;
    wire rdy_shared_en;
    ////////////////////////////////////////////////////////////////////////
    assign sync_mode = aux_pin_function_select_ff[`SPC_SYNC_HI:`SPC_SYNC_LO];
    assign aux_one_function =
        aux_pin_function_select_ff[`SPC_AUX1_HI:`SPC_AUX1_LO];
    assign ready_release_select = aux_pin_function_select_ff[`SPC_RDLY_BIT];
    assign output_drive_boost = aux_pin_function_select_ff[`SPC_DRIVE_BIT];
    assign rdy_on_aux = (aux_one_function == `SPC_AUX_RDY);

    always @* begin
        nxt_sel = aux_pin_function_select_ff;
        if (reg_wr) begin
            // Read-only bits always read back as zero
            nxt_sel = reg_wdata & `SPC_RW_MASK;
        end
    end

    // Read data comes straight from the register flops
    always @* begin
        reg_rdata = aux_pin_function_select_ff;
    end

    always @(posedge clk) begin
        if (!rstn) begin
            // Reset selects default sync and last-clock ready release
            aux_pin_function_select_ff <= `SPC_REG_RESET;
        end else begin
            aux_pin_function_select_ff <= nxt_sel;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Sync input decode; code 00 and reserved 11 leave the pin without
    // effect, so a stray write cannot stall the converter
    always @* begin
        sync_hold_core = 1'b0;
        sync_hold_step = 1'b0;
        case (sync_mode)
            `SPC_SYNC_OFF: begin
                // Pin ignored entirely
                sync_hold_core = 1'b0;
                sync_hold_step = 1'b0;
            end
            `SPC_SYNC_DEF: begin
                sync_hold_core = !sync_in_n;
                sync_hold_step = 1'b0;
            end
            `SPC_SYNC_ALT: begin
                // Sequencer keeps its state; only the step waits
                sync_hold_core = 1'b0;
                sync_hold_step = multi_chan && !sync_in_n;
            end
            default: begin
                sync_hold_core = 1'b0;
                sync_hold_step = 1'b0;
            end
        endcase
    end

    assign core_reset = sync_hold_core;
    assign seq_reset = sync_hold_core;
    // One enabled channel: sync_hold_step never applies; only sync_hold_core can stop the step
    assign seq_advance = seq_step_req && !sync_hold_core &&
        !sync_hold_step;
    ////////////////////////////////////////////////////////////////////////
    // Start is retimed by a counter; latency lands at the low end of range,
    // so converters sharing one sync output all see the same delay
    function [3:0] div_latency;
        input [1:0] sel;
        begin
            case (sel)
                `SPC_DIV4_CODE: div_latency = `SPC_DIV4_LAT;
                `SPC_DIV8_CODE: div_latency = `SPC_DIV8_LAT;
                default: div_latency = `SPC_DIV2_LAT;
            endcase
        end
    endfunction

    assign start_edge = start_in && !start_ff;
    always @* begin
        lat = div_latency(clock_div_sel);
        nxt_dly_cnt = dly_cnt_ff;
        nxt_sync_out = sync_out_ff;
        if (start_edge) begin
            // The sampling edge itself counts as the first clock
            nxt_dly_cnt = lat - 4'h1;
        end else if (dly_cnt_ff != 4'h0) begin
            nxt_dly_cnt = dly_cnt_ff - 4'h1;
            if (dly_cnt_ff == 4'h1) begin
                nxt_sync_out = start_ff;
            end
        end
        // A start shorter than one clock less than the latency gives no output pulse
        if (!start_in && !start_ff && dly_cnt_ff == 4'h0) begin
            nxt_sync_out = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            dly_cnt_ff <= 4'h0;
            start_ff <= 1'b0;
            sync_out_ff <= 1'b0;
        end else begin
            dly_cnt_ff <= nxt_dly_cnt;
            start_ff <= start_in;
            sync_out_ff <= nxt_sync_out;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always @* begin
        aux_one_oe = 1'b0;
        aux_one_out = 1'b0;
        // Reserved code 11 releases the pin, the same as code 00
        case (aux_one_function)
            `SPC_AUX_OFF: begin
                aux_one_oe = 1'b0;
                aux_one_out = 1'b0;
            end
            `SPC_AUX_RDY: begin
                // Ready is active low on the pin
                aux_one_oe = 1'b1;
                aux_one_out = !data_ready;
            end
            `SPC_AUX_SOUT: begin
                // Retimed start, meant for the sync inputs of siblings
                aux_one_oe = 1'b1;
                aux_one_out = sync_out_ff;
            end
            default: aux_one_oe = 1'b0;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    // Ready stays off the shared pin from a read until the chosen release
    assign rdy_release = ready_release_select ?
        cs_rise : last_sclk_rise;

    // A read in progress wins over a release in the same cycle
    always @* begin
        nxt_rdy_hold = rdy_hold_ff;
        if (read_active) begin
            nxt_rdy_hold = 1'b1;
        end else if (rdy_release) begin
            nxt_rdy_hold = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            rdy_hold_ff <= 1'b0;
        end else begin
            rdy_hold_ff <= nxt_rdy_hold;
        end
    end

    assign rdy_shared_en = !rdy_hold_ff && !read_active;
    // Ready on aux one takes the shared pin's ready role away entirely,
    // whatever the release select holds
    assign sdo_ready_en = rdy_shared_en && !rdy_on_aux;
    assign sdo_ready_n = !data_ready;
endmodule // spc_pin_ctrl

// ### spc_pin_ctrl_properties.sv
// Port relations of spc_pin_ctrl.
// Assumes binding to every spc_pin_ctrl instance.
`timescale 1ns/1ps
module spc_pin_ctrl_props (
    input wire clk,
    input wire rstn,
    input wire [15:0] reg_rdata,
    input wire [1:0] clock_div_sel,
    input wire multi_chan,
    input wire seq_step_req,
    input wire sync_in_n,
    input wire start_in,
    input wire core_reset,
    input wire seq_reset,
    input wire seq_advance,
    input wire aux_one_out,
    input wire aux_one_oe,
    input wire sdo_ready_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire [1:0] sm = reg_rdata[3:2];
    wire [1:0] am = reg_rdata[5:4];
    sequence s_go;
        $rose(start_in) && am == 2'h2 && clock_div_sel == 2'h0;
    endsequence
    sequence s_go4;
        $rose(start_in) && am == 2'h2 && clock_div_sel == 2'h2;
    endsequence
    sequence s_go8;
        $rose(start_in) && am == 2'h2 && clock_div_sel == 2'h3;
    endsequence
    property p_def; sm == 2'h1 && !sync_in_n |-> core_reset; endproperty
    a_def: assert property (p_def) else $error("no hold");
    property p_seq; sm == 2'h1 && !sync_in_n |-> seq_reset; endproperty
    a_seq: assert property (p_seq) else $error("no seq reset");
    property p_off; sm == 2'h0 |-> !core_reset; endproperty
    a_off: assert property (p_off) else $error("sync not off");
    property p_alt; sm == 2'h2 |-> !seq_reset; endproperty
    a_alt: assert property (p_alt) else $error("alt reset");
    property p_stop; sm == 2'h2 && multi_chan && !sync_in_n |-> !seq_advance;
    endproperty
    a_stop: assert property (p_stop) else $error("no stop");
    property p_one; sm == 2'h2 && !multi_chan |-> seq_advance == seq_step_req;
    endproperty
    a_one: assert property (p_one) else $error("one chan");
    property p_oe; am == 2'h2 |-> aux_one_oe; endproperty
    a_oe: assert property (p_oe) else $error("no drive");
    property p_rdy; am == 2'h1 |-> !sdo_ready_en; endproperty
    a_rdy: assert property (p_rdy) else $error("ready shared");
    property p_lat; s_go |-> ##[3:4] aux_one_out; endproperty
    a_lat: assert property (p_lat) else $error("sync late");
    property p_lat4; s_go4 |-> ##[5:8] aux_one_out; endproperty
    a_lat4: assert property (p_lat4) else $error("sync late div4");
    property p_lat8; s_go8 |-> ##[9:16] aux_one_out; endproperty
    a_lat8: assert property (p_lat8) else $error("sync late div8");
endmodule // spc_pin_ctrl_props
bind spc_pin_ctrl spc_pin_ctrl_props u_props (.*);

// ### spc_host_model.sv
// Host serial side: one register read per go pulse.
// Assumes go is a single-cycle pulse on clk.
`timescale 1ns/1ps
module spc_host_model (
    input wire clk,
    input wire go,
    output reg read_active = 1'b0,
    output reg last_sclk_rise = 1'b0,
    output reg cs_rise = 1'b0
);
    reg [2:0] cnt_ff = 3'h0;
    // Last clock rise comes a cycle before chip-select rises
    always @(posedge clk) begin
        cnt_ff <= go ? 3'h5 : cnt_ff - {2'h0, cnt_ff != 3'h0};
        read_active <= go || cnt_ff > 3'h2;
        last_sclk_rise <= cnt_ff == 3'h2;
        cs_rise <= cnt_ff == 3'h1;
    end
endmodule // spc_host_model

// ### spc_pin_ctrl_bench.sv
// Bench for spc_pin_ctrl with a host read model.
`timescale 1ns/1ps
module spc_pin_ctrl_bench;
    reg clk = 0, rstn = 0, reg_wr = 0, multi_chan = 0, seq_step_req = 0;
    reg sync_in_n = 1, start_in = 0, go = 0, data_ready = 1;
    reg [1:0] div_sel = 2'h0;
    reg [15:0] reg_wdata = 16'h0000;
    wire [15:0] reg_rdata;
    wire read_active, last_sclk_rise, cs_rise, core_reset, seq_reset;
    wire seq_advance, aux_one_out, aux_one_oe, sdo_ready_en;
    wire sdo_ready_n, output_drive_boost;
    integer bad_count = 0, samples_checked = 0;
    spc_pin_ctrl uut (.clk, .rstn, .reg_wr, .reg_wdata, .reg_rdata,
        .clock_div_sel(div_sel), .multi_chan, .seq_step_req, .sync_in_n,
        .start_in, .data_ready, .read_active, .last_sclk_rise,
        .cs_rise, .core_reset, .seq_reset, .seq_advance, .aux_one_out,
        .aux_one_oe, .sdo_ready_en, .sdo_ready_n, .output_drive_boost);
    spc_host_model host (.clk, .go, .read_active, .last_sclk_rise, .cs_rise);
    initial begin
        forever #12.5 clk = ~clk;
    end
    task step(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task wr(input [15:0] d);
        reg_wr = 1;
        reg_wdata = d;
        step(1);
        reg_wr = 0;
        step(1);
    endtask
    // One host read; ready must still be off after n edges, on after n+1
    task rd_release(input [15:0] cfg, input integer n);
        wr(cfg);
        go = 1;
        step(1);
        go = 0;
        step(n - 1);
        chk(sdo_ready_en, 16'h0000);
        step(1);
        chk(sdo_ready_en, 16'h0001);
    endtask
    // Sync output must be low before lo edges and high by hi edges
    task sync_lat(input [1:0] sel, input integer lo, input integer hi);
        div_sel = sel;
        start_in = 1;
        step(lo - 1);
        chk(aux_one_out, 16'h0000);
        step(hi - lo + 1);
        chk(aux_one_out, 16'h0001);
        start_in = 0;
        step(2);
        chk(aux_one_out, 16'h0000);
    endtask
    task complete_run;
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #20000;
        bad_count = bad_count + 1;
        complete_run;
    end
    initial begin
        step(20);
        rstn = 1;
        chk(reg_rdata, 16'h0004);
        wr(16'hffa7);
        chk(reg_rdata, 16'h40a7);
        chk(output_drive_boost, 16'h0001);
        chk(aux_one_oe, 16'h0001);
        wr(16'h0004);
        sync_in_n = 0;
        step(1);
        chk(core_reset, 1);
        wr(16'h0008);
        multi_chan = 1;
        seq_step_req = 1;
        step(1);
        chk(seq_advance, 0);
        sync_in_n = 1;
        step(1);
        chk(seq_advance, 1);
        multi_chan = 0;
        sync_in_n = 0;
        step(1);
        chk(seq_advance, 1);
        $display("sync modes done");
        wr(16'h0011);
        chk(core_reset, 16'h0000);
        data_ready = 0;
        go = 1;
        step(1);
        go = 0;
        chk(aux_one_oe, 16'h0001);
        chk(aux_one_out, 16'h0001);
        chk(sdo_ready_n, 16'h0001);
        chk(sdo_ready_en, 0);
        data_ready = 1;
        step(8);
        chk(sdo_ready_en, 0);
        rd_release(16'h0004, 5);
        rd_release(16'h0005, 6);
        $display("ready done");
        wr(16'h00a4);
        sync_lat(2'h0, 3, 4);
        sync_lat(2'h2, 5, 8);
        sync_lat(2'h3, 9, 16);
        $display("sync out done");
        complete_run;
    end
endmodule // spc_pin_ctrl_bench
